// ### include/frp_pkg.sv
// Purpose: shared constants for the flash row program sequencer
// Assumes: 50 MHz core clock, byte-wide array with 16-bit addresses
// Notes:   times are kept in ns, cycle counts derive from them
package frp_pkg;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int        FRP_ADDR_W  = 16;       // array address width
  localparam int        FRP_DATA_W  = 8;        // array byte width
  localparam int        FRP_ROW_B   = 64;       // bytes in one row
  localparam int        FRP_ROW_LSB = 6;        // lowest address bit naming the row
  localparam logic [7:0] FRP_ERASED = 8'hff;    // content of an erased byte

  // ************************************************************
  // timing
  // ************************************************************
  localparam int FRP_CLK_MHZ    = 50;           // core clock rate
  localparam int FRP_T_RECOV_NS = 1000;         // read_recovery_time, typical
  // recovery is a least time for the reader, so round up
  localparam int FRP_RECOV_CYC  = (FRP_T_RECOV_NS * FRP_CLK_MHZ + 999) / 1000;

endpackage : frp_pkg

// ### include/frp_tmr_if.sv
// Purpose: start / busy pair between the sequencer and its recovery timer
// Assumes: both ends on CORE_CLK
// Notes:   start is a one-cycle pulse, busy a level
`timescale 1ns/1ps
`default_nettype none
interface frp_tmr_if;
  logic start;   // restart the interval
  logic busy;    // interval still running

  modport ctl (output start, input busy);
  modport tmr (input start, output busy);
endinterface : frp_tmr_if
`default_nettype wire

// ### hw/frp_timer.sv
// Purpose: one-shot interval counter for the read recovery wait
// Assumes: start is a single-cycle pulse on CORE_CLK
// Notes:   a start while busy restarts the interval from full
`timescale 1ns/1ps
`default_nettype none
module frp_timer
  import frp_pkg::*;
#(
  parameter int CYCLES = FRP_RECOV_CYC           // interval length in cycles
) (
  input  wire logic clk,                         // core clock
  input  wire logic nrst,                        // async reset, active low
  frp_tmr_if.tmr    tif                          // start / busy
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(CYCLES);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // ************************************************************
  // down counter
  // ************************************************************
  // load on start, count to zero, then hold
  always_comb begin
    cnt_next = cnt_reg;
    if (tif.start) begin
      cnt_next = CNT_LOAD;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tif.busy = (cnt_reg != '0);

endmodule : frp_timer
`default_nettype wire

// ### hw/frp_row_prog.sv
// Purpose: row program sequencer between the processor writes and the array
// Assumes: processor signals and array read data are on CORE_CLK
// Notes:   array read data is valid one cycle after ARR_RD
//
// What this block does
// - rows are 64 aligned bytes, starting at low address 00, 40, 80 or c0
// - a cycle whose writes span two rows fails and programs nothing further
// - only bytes that currently read all ones are programmed
// - setting program select enters program mode; after the row select write, writes latch address and data only while high voltage is on
// - reads are valid only a recovery time after high voltage clears
`timescale 1ns/1ps
`default_nettype none
module frp_row_prog
  import frp_pkg::*;
#(
  parameter int AW        = FRP_ADDR_W,          // address width
  parameter int RECOV_CYC = FRP_RECOV_CYC        // read recovery in cycles
) (
  input  wire logic                  CORE_CLK,   // core clock
  input  wire logic                  NRST,       // async reset, active low
  input  wire logic                  PGM_SEL,    // program_select_bit level
  input  wire logic                  HV_EN,      // high_voltage_enable_bit level
  input  wire logic                  CPU_WR,     // processor write to array space
  input  wire logic [AW-1:0]         CPU_ADDR,   // processor write address
  input  wire logic [FRP_DATA_W-1:0] CPU_WDATA,  // processor write data
  input  wire logic [FRP_DATA_W-1:0] ARR_RDATA,  // array byte, one cycle after ARR_RD
  output logic                       ARR_RD,     // erased check read strobe
  output logic                       ARR_PROG,   // program strobe for one byte
  output logic [AW-1:0]              ARR_ADDR,   // latched byte address
  output logic [FRP_DATA_W-1:0]      ARR_WDATA,  // latched byte data
  output logic                       PROG_CFG,   // array in program configuration
  output logic                       ROW_FAIL,   // current cycle crossed a row
  output logic                       NOT_ERASED, // a write hit an unerased byte
  output logic                       READ_VALID  // normal reads may be trusted
);

  typedef enum logic [1:0] {PH_IDLE, PH_ARMED, PH_SELECTED} frp_phase_t;
  typedef enum logic [1:0] {BP_NONE, BP_READ, BP_CHECK} frp_bstep_t;

  localparam int RW = AW - FRP_ROW_LSB;

  frp_phase_t            phase_reg,  phase_next;
  frp_bstep_t            bstep_reg,  bstep_next;
  logic [RW-1:0]         row_reg,    row_next;
  logic [AW-1:0]         addr_reg,   addr_next;
  logic [FRP_DATA_W-1:0] data_reg,   data_next;
  logic                  fail_reg,   fail_next;
  logic                  nerase_reg, nerase_next;
  logic                  prog_reg,   prog_next;
  logic                  hv_reg;
  logic                  burn_ok;
  logic                  same_row;

  frp_tmr_if tif ();

  // ************************************************************
  // read recovery timer
  // ************************************************************
  frp_timer #(
    .CYCLES (RECOV_CYC)
  ) u_recov (
    .clk  (CORE_CLK),
    .nrst (NRST),
    .tif  (tif)
  );

  // restart on the falling edge of high voltage
  assign tif.start = hv_reg & ~HV_EN;

  // ************************************************************
  // sequencer next state
  // ************************************************************
  // row index is the address with the in-row offset stripped
  assign same_row = (CPU_ADDR[AW-1:FRP_ROW_LSB] == row_reg);
  // both bits must stand for a byte to be burned
  assign burn_ok  = PGM_SEL & HV_EN & ~fail_reg;

  always_comb begin
    phase_next  = phase_reg;
    bstep_next  = bstep_reg;
    row_next    = row_reg;
    addr_next   = addr_reg;
    data_next   = data_reg;
    fail_next   = fail_reg;
    nerase_next = nerase_reg;
    prog_next   = 1'b0;
    unique case (phase_reg)
      PH_IDLE: begin
        if (PGM_SEL) begin
          // a fresh cycle clears the old verdicts
          phase_next  = PH_ARMED;
          fail_next   = 1'b0;
          nerase_next = 1'b0;
        end
      end
      PH_ARMED: begin
        if (!PGM_SEL) begin
          phase_next = PH_IDLE;
        end else if (CPU_WR) begin
          // first write only picks the row, its data is dropped
          row_next   = CPU_ADDR[AW-1:FRP_ROW_LSB];
          phase_next = PH_SELECTED;
        end
      end
      PH_SELECTED: begin
        if (!PGM_SEL) begin
          phase_next = PH_IDLE;
        end else if (CPU_WR && !same_row) begin
          fail_next = 1'b1;
        end else if (CPU_WR && burn_ok && bstep_reg == BP_NONE) begin
          addr_next  = CPU_ADDR;
          data_next  = CPU_WDATA;
          bstep_next = BP_READ;
        end
      end
      default: phase_next = PH_IDLE;
    endcase
    // byte pipeline: read back, then burn only an erased byte
    unique case (bstep_reg)
      BP_NONE:  ;
      BP_READ:  bstep_next = BP_CHECK;
      BP_CHECK: begin
        bstep_next = BP_NONE;
        if (ARR_RDATA == FRP_ERASED) begin
          prog_next = burn_ok & ~fail_next;
        end else begin
          nerase_next = 1'b1;
        end
      end
      default: bstep_next = BP_NONE;
    endcase
  end

  // ************************************************************
  // sequencer registers
  // ************************************************************
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      phase_reg  <= PH_IDLE;
      bstep_reg  <= BP_NONE;
      row_reg    <= '0;
      addr_reg   <= '0;
      data_reg   <= '0;
      fail_reg   <= 1'b0;
      nerase_reg <= 1'b0;
      prog_reg   <= 1'b0;
      hv_reg     <= 1'b0;
    end else begin
      phase_reg  <= phase_next;
      bstep_reg  <= bstep_next;
      row_reg    <= row_next;
      addr_reg   <= addr_next;
      data_reg   <= data_next;
      fail_reg   <= fail_next;
      nerase_reg <= nerase_next;
      prog_reg   <= prog_next;
      hv_reg     <= HV_EN;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // address and data hold through read and burn, so the array sees them steady
  assign ARR_RD     = (bstep_reg == BP_READ);
  assign ARR_PROG   = prog_reg;
  assign ARR_ADDR   = addr_reg;
  assign ARR_WDATA  = data_reg;
  assign PROG_CFG   = (phase_reg != PH_IDLE);
  assign ROW_FAIL   = fail_reg;
  assign NOT_ERASED = nerase_reg;
  // reads are blocked while high voltage is up and until recovery expires
  assign READ_VALID = ~hv_reg & ~HV_EN & ~tif.busy;

endmodule : frp_row_prog
`default_nettype wire

// ### verification/frp_row_prog_properties.sv
// Purpose: port checks of the row program sequencer
// Assumes: one clock, NRST async low
// Notes:   bound into every frp_row_prog
`timescale 1ns/1ps
`default_nettype none
module frp_row_prog_properties
  import frp_pkg::*;
#(
  parameter int AW = FRP_ADDR_W  // address width
) (
  input wire logic                  CORE_CLK,   // clock
  input wire logic                  NRST,       // reset
  input wire logic                  PGM_SEL,    // select
  input wire logic                  HV_EN,      // high voltage
  input wire logic                  CPU_WR,     // write
  input wire logic [AW-1:0]         CPU_ADDR,   // address
  input wire logic [FRP_DATA_W-1:0] ARR_RDATA,  // read data
  input wire logic                  ARR_RD,     // check read
  input wire logic                  ARR_PROG,   // burn
  input wire logic [AW-1:0]         ARR_ADDR,   // latched
  input wire logic                  PROG_CFG,   // mode
  input wire logic                  ROW_FAIL,   // crossed
  input wire logic                  NOT_ERASED, // not ff
  input wire logic                  READ_VALID  // reads ok
);
  // *****
  // properties
  // *****
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  chk_burn_after_read: assert property (ARR_PROG |-> $past(ARR_RD, 2))
    else $error("burn without read");
  chk_burn_erased_only: assert property (ARR_PROG |-> $past(ARR_RDATA) == FRP_ERASED)
    else $error("burn of used byte");
  chk_burn_needs_both: assert property (ARR_PROG |-> $past(PGM_SEL && HV_EN))
    else $error("burn without enables");
  chk_fail_blocks_burn: assert property (ARR_PROG |-> !$past(ROW_FAIL))
    else $error("burn after crossing");
  chk_latch_write: assert property (ARR_RD |-> $past(CPU_WR) && ARR_ADDR == $past(CPU_ADDR))
    else $error("bad latch");
  chk_mode_entry: assert property (PGM_SEL && !PROG_CFG |=> PROG_CFG && !ROW_FAIL && !NOT_ERASED)
    else $error("bad mode entry");
  chk_used_flag: assert property ($rose(NOT_ERASED) |-> $past(ARR_RDATA) != FRP_ERASED)
    else $error("false used flag");
  chk_read_recovery: assert property ($fell(HV_EN) |-> (!READ_VALID)[*3] ##[1:1000] READ_VALID)
    else $error("bad recovery");
endmodule : frp_row_prog_properties
bind frp_row_prog frp_row_prog_properties #(.AW(AW)) u_props (.CORE_CLK(CORE_CLK), .NRST(NRST),
  .PGM_SEL(PGM_SEL), .HV_EN(HV_EN), .CPU_WR(CPU_WR), .CPU_ADDR(CPU_ADDR), .ARR_RDATA(ARR_RDATA),
  .ARR_RD(ARR_RD), .ARR_PROG(ARR_PROG), .ARR_ADDR(ARR_ADDR), .PROG_CFG(PROG_CFG), .ROW_FAIL(ROW_FAIL),
  .NOT_ERASED(NOT_ERASED), .READ_VALID(READ_VALID));
`default_nettype wire

// ### verification/frp_array_model.sv
// Purpose: array model answering the erased check
// Assumes: read data due the cycle after rd
// Notes:   keeps only the low address byte
`timescale 1ns/1ps
`default_nettype none
module frp_array_model
  import frp_pkg::*;
(
  input  wire logic       clk,   // clock
  input  wire logic       rd,    // check read
  input  wire logic       prog,  // burn
  input  wire logic [7:0] addr,  // low address
  input  wire logic [7:0] wdata, // byte to burn
  output logic      [7:0] rdata  // read data
);
  // *****
  // storage
  // *****
  logic [7:0] mem [256];
  initial foreach (mem[i]) mem[i] = FRP_ERASED;
  // burning only clears bits; between reads the bus flips so no stale byte passes
  always @(posedge clk) begin
    if (prog) mem[addr] <= mem[addr] & wdata;
    rdata <= rd ? mem[addr] : ~rdata;
  end
endmodule : frp_array_model
`default_nettype wire

// ### verification/frp_row_prog_test.sv
// Purpose: directed tests of the row program sequencer
// Assumes: 50 MHz clock, recovery cut to 5 cycles
// Notes:   array answered by frp_array_model
`timescale 1ns/1ps
`default_nettype none
module frp_row_prog_test;
  localparam int RC = 5;  // short recovery keeps the run brief
  // software waits in 50 MHz cycles, kept at their minimums
  localparam int NONVOLATILE_SETUP_TIME  = 500;   // nonvolatile_setup_time, 10 us
  localparam int PROGRAM_SETUP_TIME  = 250;   // program_setup_time, 5 us
  localparam int BYTE_PROGRAM_TIME = 1500;  // byte_program_time, 30 us
  localparam int NONVOLATILE_HOLD_TIME  = 250;   // nonvolatile_hold_time, 5 us
  logic clk, nrst, pgm_sel, hv_en, cpu_wr, arr_rd, arr_prog, prog_cfg, row_fail, not_erased, read_valid;
  logic [15:0] cpu_addr, arr_addr;
  logic [7:0]  cpu_wdata, arr_rdata, arr_wdata;
  int n_errors = 0;
  int total_checks = 0;
  // *****
  // design, array, clock
  // *****
  frp_row_prog #(.RECOV_CYC(RC)) uut (.CORE_CLK(clk), .NRST(nrst), .PGM_SEL(pgm_sel), .HV_EN(hv_en),
    .CPU_WR(cpu_wr), .CPU_ADDR(cpu_addr), .CPU_WDATA(cpu_wdata), .ARR_RDATA(arr_rdata), .ARR_RD(arr_rd),
    .ARR_PROG(arr_prog), .ARR_ADDR(arr_addr), .ARR_WDATA(arr_wdata), .PROG_CFG(prog_cfg),
    .ROW_FAIL(row_fail), .NOT_ERASED(not_erased), .READ_VALID(read_valid));
  frp_array_model u_arr (.clk(clk), .rd(arr_rd), .prog(arr_prog), .addr(arr_addr[7:0]),
    .wdata(arr_wdata), .rdata(arr_rdata));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // wait n edges, then look at settled outputs
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc
  // software idles for n edges between procedure steps
  task automatic sw_wait(input int n);
    repeat (n) @(posedge clk);
  endtask : sw_wait
  task automatic ctl(input logic s, input logic h);
    @(posedge clk);
    pgm_sel <= s;
    hv_en <= h;
  endtask : ctl
  // one write, then five cycles watching for the burn
  task automatic burn(input logic [15:0] a, input logic [7:0] d, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_wr <= 1'b0;
    repeat (5) begin
      @(negedge clk);
      if (arr_prog === 1'b1) begin
        seen = 1'b1;
        chk(arr_addr, a);
        chk({8'h00, arr_wdata}, {8'h00, d});
      end
    end
    chk(16'(seen), 16'(exp));
  endtask : burn
  task automatic t_program;
    ctl(1'b1, 1'b0);
    cyc(1);
    chk(16'(prog_cfg), 16'h1);
    // row select write follows program select; block protect read has no pin here
    burn(16'h1240, 8'h00, 1'b0);
    burn(16'h1245, 8'h5a, 1'b0);
    sw_wait(NONVOLATILE_SETUP_TIME);
    ctl(1'b1, 1'b1);
    cyc(0);
    chk(16'(read_valid), 16'h0);
    sw_wait(PROGRAM_SETUP_TIME);
    burn(16'h1245, 8'h5a, 1'b1);
    sw_wait(BYTE_PROGRAM_TIME);
    burn(16'h127f, 8'ha5, 1'b1);
    sw_wait(BYTE_PROGRAM_TIME);
    burn(16'h1245, 8'h00, 1'b0);
    chk(16'(not_erased), 16'h1);
    sw_wait(BYTE_PROGRAM_TIME);
    ctl(1'b0, 1'b1);
    cyc(1);
    chk(16'(prog_cfg), 16'h0);
    sw_wait(NONVOLATILE_HOLD_TIME);
    ctl(1'b0, 1'b0);
    cyc(RC - 1);
    chk(16'(read_valid), 16'h0);
    cyc(3);
    chk(16'(read_valid), 16'h1);
    $display("t_program done");
  endtask : t_program
  task automatic t_cross;
    ctl(1'b1, 1'b1);
    cyc(1);
    chk({14'h0, row_fail, not_erased}, 16'h0);
    burn(16'h1280, 8'h00, 1'b0);
    burn(16'h12c0, 8'h11, 1'b0);
    chk(16'(row_fail), 16'h1);
    burn(16'h1281, 8'h22, 1'b0);
    ctl(1'b0, 1'b0);
    cyc(RC + 3);
    $display("t_cross done");
  endtask : t_cross
  // the bench stands for code running from outside the array
  // no other access enters the array space between steps
  // the bench raises no interrupts during a program cycle
  // waits sit at their minimums, far inside any per-byte or row maximum
  initial begin
    {nrst, pgm_sel, hv_en, cpu_wr} = 4'h0;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    cyc(0);
    chk({14'h0, prog_cfg, read_valid}, 16'h1);
    t_program();
    t_cross();
    wrap_up();
  end
  // tests need about 5500 cycles; margin of more than three-fold
  initial begin
    #400000;
    n_errors++;
    wrap_up();
  end
endmodule : frp_row_prog_test
`default_nettype wire
